// *** dv/acr_link_model.sv ***
// link engine model: hands whole words to the block over the link side
// assumes acr_regs answers with busy and ready levels on link_clk
`timescale 1ns/100ps
module acr_link_model (
  input wire logic link_clk,
  output logic wr_stb,
  output logic rd_stb,
  output logic [3:0] ptr,
  output logic [15:0] wdata,
  output logic byte_ack,
  input wire logic req_busy,
  input wire logic rd_ready,
  input wire logic [7:0] rd_byte
);
  // idle: no request, stale fields
  initial
  begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ptr = 4'hF;
    wdata = 16'hFFFF;
    byte_ack = 1'b0;
  end
  // one-cycle strobe, then fields turned over so nothing stale looks valid
  task automatic strobe(input logic wr, input logic [3:0] p, input logic [15:0] d);
    @(negedge link_clk);
    wr_stb = wr;
    rd_stb = !wr;
    ptr = p;
    wdata = d;
    @(negedge link_clk);
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ptr = ~p;
    wdata = ~d;
  endtask
  // bounded wait for the core round trip, then optional stall
  task automatic wait_idle(input int slow);
    int n;
    n = 0;
    while (req_busy !== 1'b0 && n < 300)
    begin
      @(negedge link_clk);
      n++;
    end
    repeat (slow) @(negedge link_clk);
  endtask
  // one-cycle acknowledge of the offered byte
  task automatic ack();
    byte_ack = 1'b1;
    @(negedge link_clk);
    byte_ack = 1'b0;
    @(negedge link_clk);
  endtask
  // whole sixteen-bit write, never a single byte
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    strobe(1'b1, p, d);
    wait_idle(0);
  endtask
  // two-byte read, high byte first, both bytes taken
  task automatic rd(input logic [3:0] p, input int slow, output logic [15:0] w);
    strobe(1'b0, p, 16'h0000);
    wait_idle(slow);
    w = 16'hxxxx;
    if (rd_ready === 1'b1)
    begin
      w[15:8] = rd_byte;
      ack();
      repeat (slow) @(negedge link_clk);
      w[7:0] = rd_byte;
      ack();
    end
  endtask
endmodule

// *** dv/test_adc_config_and_result_regs.sv ***
// self-checking bench for the converter configuration and result logic
// assumes acr_link_model on the link side and a converter model here
`timescale 1ns/100ps
module test_adc_config_and_result_regs;
  import acr_pkg::*;
  logic clk = 1'b0; // core clock, 20 ns
  logic link_clk = 1'b0; // link clock, 15 ns
  logic resetn = 1'b0;
  logic wr_stb, rd_stb, byte_ack, req_busy, rd_ready;
  logic [3:0] ptr;
  acr_word_t wdata;
  logic [7:0] rd_byte, rd_byte10, viol;
  logic conv_pin = 1'b0; // start pin
  logic adc_done = 1'b0, lim_mon = 1'b0, adc_start, filt, pin_out, pin_oe;
  logic [2:0] adc_chan, cv_ch = 3'h0;
  acr_data_t adc_data = 12'h000, lim_up = 12'h800, cv_base = 12'h100;
  int error_cnt = 0, tests_run = 0, cyc = 0, cnt = 0;
  logic [2:0] seen_q[$]; // channels launched, in order
  acr_word_t w;
  always #10 clk = ~clk;
  always #7.5 link_clk = ~link_clk;
  acr_regs dut (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .lnk_wr_stb(wr_stb), .lnk_rd_stb(rd_stb), .lnk_ptr(ptr), .lnk_wdata(wdata),
    .lnk_byte_ack(byte_ack), .lnk_req_busy(req_busy), .lnk_rd_ready(rd_ready),
    .lnk_rd_byte(rd_byte), .conv_start_pin(conv_pin), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
    .lim_monitored(lim_mon), .lim_upper(lim_up), .bus_glitch_filter_enable(filt),
    .viol_status(viol), .status_pin_out(pin_out), .status_pin_oe(pin_oe));
  acr_link_model lm (.link_clk(link_clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .ptr(ptr), .wdata(wdata), .byte_ack(byte_ack), .req_busy(req_busy),
    .rd_ready(rd_ready), .rd_byte(rd_byte));
  // ten-bit build in lockstep on the same inputs; only its offered byte is watched
  acr_regs #(.TEN_BIT(1'b1)) dut_ten (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .lnk_wr_stb(wr_stb), .lnk_rd_stb(rd_stb), .lnk_ptr(ptr), .lnk_wdata(wdata),
    .lnk_byte_ack(byte_ack), .lnk_req_busy(), .lnk_rd_ready(),
    .lnk_rd_byte(rd_byte10), .conv_start_pin(conv_pin), .adc_start(), .adc_chan(),
    .adc_done(adc_done), .adc_data(adc_data), .lim_monitored(lim_mon),
    .lim_upper(lim_up), .bus_glitch_filter_enable(), .viol_status(),
    .status_pin_out(), .status_pin_oe());
  // converter: done four cycles after each launch, data base plus channel
  always @(negedge clk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (cnt == 1)
    begin
      adc_done <= 1'b1;
      adc_data <= cv_base + 12'(cv_ch);
      lim_mon <= (cv_ch < 3'h4);
    end
    if (cnt != 0)
      cnt <= cnt - 1;
    if (adc_start === 1'b1)
    begin
      cnt <= 4;
      cv_ch <= adc_chan;
      seen_q.push_back(adc_chan);
    end
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // raise the start pin; bounded wait for n launches, then settle
  task automatic convert(input int n, input int settle);
    int k;
    k = 0;
    if (conv_pin == 1'b0)
      seen_q.delete();
    conv_pin = 1'b1;
    while (seen_q.size() < n && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    chk(16'(seen_q.size() >= n), 16'h0001, "launch wait");
    repeat (settle) @(negedge clk);
    conv_pin = 1'b0;
  endtask
  // reset values, unmapped pointers, slow host
  task automatic t_reset();
    lm.rd(4'h2, 3, w);
    chk(w, 16'h0008, "config reset");
    chk(16'(filt), 16'h0001, "filter reset");
    chk(16'(pin_oe), 16'h0000, "pin off");
    lm.wr(4'h5, 16'hFFFF);
    lm.rd(4'h1, 0, w);
    chk(w, 16'h0000, "unmapped read");
    lm.rd(4'h2, 0, w);
    chk(w, 16'h0008, "unmapped write dropped");
    $display("test reset done");
  endtask
  // filter off, readback
  task automatic t_filter();
    lm.wr(4'h2, 16'h0000);
    repeat (5) @(negedge clk);
    chk(16'(filt), 16'h0000, "filter off");
    chk(16'(pin_oe), 16'h0000, "no pin role");
    lm.rd(4'h2, 0, w);
    chk(w, 16'h0000, "config readback");
    $display("test filter done");
  endtask
  // channels 2,5,8, busy role active high
  task automatic t_seq();
    lm.wr(4'h2, 16'h0923);
    repeat (5) @(negedge clk);
    // pin stays high through the run so one edge starts all three channels
    seen_q.delete();
    conv_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk(16'({pin_oe, pin_out}), 16'h0003, "busy active");
    convert(3, 14);
    chk(16'({pin_oe, pin_out}), 16'h0002, "busy idle");
    chk(16'(seen_q.size()), 16'h0003, "launch count");
    chk(16'({seen_q[0], seen_q[1], seen_q[2]}), 16'h0067, "order");
    lm.rd(4'h0, 1, w);
    chk(w, 16'h7107, "result ch8");
    chk(16'(rd_byte10), 16'h0004, "ten-bit low byte");
    lm.wr(4'h0, 16'hFFFF);
    lm.rd(4'h0, 0, w);
    chk(w, 16'h7107, "result read only");
    $display("test sequence done");
  endtask
  // alert role active low, violation, clear
  task automatic t_alert();
    cv_base = 12'h900;
    lm.wr(4'h2, 16'h0014);
    repeat (5) @(negedge clk);
    convert(1, 14);
    chk(16'(viol), 16'h0002, "upper status");
    chk(16'({pin_oe, pin_out}), 16'h0002, "alert low");
    lm.rd(4'h0, 0, w);
    chk(w, 16'h8900, "flagged ch1");
    lm.wr(4'h2, 16'h0104);
    repeat (5) @(negedge clk);
    convert(1, 14);
    lm.rd(4'h0, 0, w);
    chk(w, 16'hC904, "flag from other ch");
    lm.wr(4'h2, 16'h0106);
    repeat (5) @(negedge clk);
    chk(16'(viol), 16'h0000, "status cleared");
    chk(16'({pin_oe, pin_out}), 16'h0003, "alert released");
    lm.rd(4'h2, 0, w);
    chk(w, 16'h0104, "clear readback");
    lm.rd(4'h0, 0, w);
    chk(w, 16'h4904, "flag cleared");
    $display("test alert done");
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge link_clk);
    t_reset();
    t_filter();
    t_seq();
    t_alert();
    print_verdict();
  end
endmodule

// *** logic/acr_defs.svh ***
// register offsets, field positions, reset values for the converter
// configuration and result logic; definitions only, no processes
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// pointer values of the two registers handled here
`define ACR_PTR_RESULT 4'h0
`define ACR_PTR_CONFIG 4'h2

// configuration register field positions
`define ACR_CFG_SEL_HI 11
`define ACR_CFG_SEL_LO 4
`define ACR_CFG_FLT 3
`define ACR_CFG_EN 2
`define ACR_CFG_BA 1
`define ACR_CFG_POL 0

// configuration reset value: only the filter bit set
`define ACR_CFG_RESET 16'h0008

// result word field positions
`define ACR_RES_FLAG 15
`define ACR_RES_TAG_HI 14
`define ACR_RES_TAG_LO 12
`define ACR_RES_DATA_HI 11

// channels with limit monitoring (channel tags 0..3)
`define ACR_MON_CHANS 3'h4

`endif

// *** logic/acr_pkg.sv ***
// types shared by the converter configuration and result logic
// assumes acr_defs.svh supplies the numeric constants
package acr_pkg;
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ACR_SEQ_IDLE = 2'b01,
    ACR_SEQ_CONV = 2'b10
  } acr_seq_state_t;
  // sixteen-bit register word
  typedef logic [15:0] acr_word_t;
  // twelve-bit conversion value
  typedef logic [11:0] acr_data_t;
endpackage

// *** logic/acr_regs.sv ***
// configuration register, result word and status pin of the converter
// assumes a link engine on link_clk passes whole words and bytes, and a
// converter and limit block on clk answering the sequencer
`timescale 1ns/100ps
`include "acr_defs.svh"
module acr_regs #(
  parameter bit TEN_BIT = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic lnk_wr_stb,
  input wire logic lnk_rd_stb,
  input wire logic [3:0] lnk_ptr,
  input wire acr_pkg::acr_word_t lnk_wdata,
  input wire logic lnk_byte_ack,
  output logic lnk_req_busy,
  output logic lnk_rd_ready,
  output logic [7:0] lnk_rd_byte,
  input wire logic conv_start_pin,
  output logic adc_start,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire acr_pkg::acr_data_t adc_data,
  input wire logic lim_monitored,
  input wire acr_pkg::acr_data_t lim_upper,
  output logic bus_glitch_filter_enable,
  output logic [7:0] viol_status,
  output logic status_pin_out,
  output logic status_pin_oe
);
  import acr_pkg::*;

  // reset word of the configuration register, sliced per field below
  localparam acr_word_t cfg_reset_word = `ACR_CFG_RESET;

  // link domain reset, released two link edges after core reset
  logic lnk_rst_n;
  // link request holding registers, stable while a request is open
  logic req_tog_r;
  logic req_wr_r;
  logic [3:0] req_ptr_r;
  acr_word_t req_data_r;
  // open request waiting for the core's answer
  logic pend_r;
  // which result byte is on offer
  logic byte_lo_r;
  logic rd_ready_r;
  logic [7:0] rd_byte_r;
  // answer toggle seen in the link domain
  logic ans_sync;
  logic ans_seen_r;

  // core side of the handshake
  logic req_sync;
  logic req_seen_r;
  logic ans_tog_r;
  acr_word_t ans_word_r;
  // configuration fields
  logic [7:0] cfg_sel_r;
  logic cfg_flt_r;
  logic cfg_en_r;
  logic cfg_ba_r;
  logic cfg_pol_r;
  // latest result and violation state
  logic [2:0] res_tag_r;
  acr_data_t res_data_r;
  logic viol_flag_r;
  logic [7:0] viol_status_r;
  logic pin_out_r;
  logic pin_oe_r;
  // conversion start pin after two flops
  logic start_sync;
  logic start_seen_r;
  // sequencer outputs
  logic seq_busy;
  logic seq_res_valid;
  logic [2:0] seq_res_chan;
  acr_data_t seq_res_data;

  // crossing stages
  acr_sync #(.WIDTH(1)) u_rst_sync (.clk(link_clk), .d(resetn), .q(lnk_rst_n));
  acr_sync #(.WIDTH(1)) u_ans_sync (.clk(link_clk), .d(ans_tog_r), .q(ans_sync));
  acr_sync #(.WIDTH(1)) u_req_sync (.clk(clk), .d(req_tog_r), .q(req_sync));
  acr_sync #(.WIDTH(1)) u_start_sync (.clk(clk), .d(conv_start_pin), .q(start_sync));

  // link side decode
  wire logic ans_evt = ans_sync != ans_seen_r;
  wire logic lnk_idle = !pend_r && !rd_ready_r;
  wire logic lnk_take = lnk_idle && (lnk_wr_stb || lnk_rd_stb);

  // link domain: take a request, wait for the answer, offer two bytes on a read
  always_ff @(posedge link_clk)
  begin
    if (!lnk_rst_n)
    begin
      req_tog_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_ptr_r <= 4'h0;
      req_data_r <= 16'h0000;
      pend_r <= 1'b0;
      byte_lo_r <= 1'b0;
      rd_ready_r <= 1'b0;
      rd_byte_r <= 8'h00;
      ans_seen_r <= 1'b0;
    end
    else
    begin
      ans_seen_r <= ans_sync;
      // write wins when both strobes come together
      if (lnk_take)
      begin
        req_tog_r <= ~req_tog_r;
        req_wr_r <= lnk_wr_stb;
        req_ptr_r <= lnk_ptr;
        req_data_r <= lnk_wdata;
        pend_r <= 1'b1;
      end
      else if (pend_r && ans_evt)
      begin
        pend_r <= 1'b0;
        rd_ready_r <= !req_wr_r;
        // high byte first
        rd_byte_r <= ans_word_r[15:8];
        byte_lo_r <= 1'b0;
      end
      else if (rd_ready_r && lnk_byte_ack)
      begin
        // second ack closes the read
        if (!byte_lo_r)
        begin
          rd_byte_r <= ans_word_r[7:0];
          byte_lo_r <= 1'b1;
        end
        else
          rd_ready_r <= 1'b0;
      end
    end
  end

  // core side decode
  wire logic req_evt = req_sync != req_seen_r;
  wire logic wr_cfg = req_evt && req_wr_r && (req_ptr_r == `ACR_PTR_CONFIG);
  // both pin bits written as one means clear
  wire logic clr_all = wr_cfg && req_data_r[`ACR_CFG_EN] && req_data_r[`ACR_CFG_BA];
  wire logic start_evt = start_sync && !start_seen_r;
  // pin role decode
  wire logic mode_busy = !cfg_en_r && cfg_ba_r;
  wire logic mode_alert = cfg_en_r && !cfg_ba_r;
  // monitored result above its upper limit
  wire logic res_over = seq_res_valid && lim_monitored
    && (seq_res_chan < `ACR_MON_CHANS) && (seq_res_data > lim_upper);
  // stored data, ten-bit variant forces the two low bits
  wire acr_data_t res_store = TEN_BIT ? {seq_res_data[11:2], 2'b00} : seq_res_data;
  // status bit for the high limit of the converted channel
  wire logic [2:0] over_bit = {seq_res_chan[1:0], 1'b1};
  wire acr_word_t cfg_word = {4'h0, cfg_sel_r, cfg_flt_r, cfg_en_r, cfg_ba_r, cfg_pol_r};
  wire acr_word_t res_word = {viol_flag_r, res_tag_r, res_data_r};
  // registers other than these two read as zero here
  wire acr_word_t rd_word = (req_ptr_r == `ACR_PTR_RESULT) ? res_word
    : (req_ptr_r == `ACR_PTR_CONFIG) ? cfg_word : 16'h0000;
  // active level before polarity
  wire logic pin_act = mode_busy ? seq_busy : (mode_alert ? viol_flag_r : 1'b0);

  // handshake answer and start edge
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      req_seen_r <= 1'b0;
      ans_tog_r <= 1'b0;
      ans_word_r <= 16'h0000;
      start_seen_r <= 1'b0;
    end
    else
    begin
      req_seen_r <= req_sync;
      start_seen_r <= start_sync;
      if (req_evt)
      begin
        ans_word_r <= rd_word;
        ans_tog_r <= ~ans_tog_r;
      end
    end
  end

  // configuration register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cfg_sel_r <= cfg_reset_word[`ACR_CFG_SEL_HI:`ACR_CFG_SEL_LO];
      cfg_flt_r <= cfg_reset_word[`ACR_CFG_FLT];
      cfg_en_r <= cfg_reset_word[`ACR_CFG_EN];
      cfg_ba_r <= cfg_reset_word[`ACR_CFG_BA];
      cfg_pol_r <= cfg_reset_word[`ACR_CFG_POL];
    end
    else if (wr_cfg)
    begin
      cfg_sel_r <= req_data_r[`ACR_CFG_SEL_HI:`ACR_CFG_SEL_LO];
      cfg_flt_r <= req_data_r[`ACR_CFG_FLT];
      cfg_en_r <= req_data_r[`ACR_CFG_EN];
      // a clear write leaves select at zero
      cfg_ba_r <= req_data_r[`ACR_CFG_BA] && !req_data_r[`ACR_CFG_EN];
      cfg_pol_r <= req_data_r[`ACR_CFG_POL];
    end
  end

  // result word and violation state, a new violation beats a clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      res_tag_r <= 3'h0;
      res_data_r <= 12'h000;
      viol_flag_r <= 1'b0;
      viol_status_r <= 8'h00;
    end
    else
    begin
      if (seq_res_valid)
      begin
        res_tag_r <= seq_res_chan;
        res_data_r <= res_store;
      end
      viol_flag_r <= res_over || (viol_flag_r && !clr_all);
      for (int i = 0; i < 8; i++)
      begin
        viol_status_r[i] <= (res_over && over_bit == 3'(i))
          || (viol_status_r[i] && !clr_all);
      end
    end
  end

  // shared status pin, polarity applied last
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_out_r <= 1'b1;
      pin_oe_r <= 1'b0;
    end
    else
    begin
      pin_out_r <= cfg_pol_r ? pin_act : !pin_act;
      pin_oe_r <= mode_busy || mode_alert;
    end
  end

  // channel sequencer
  acr_seq u_seq (
    .clk(clk),
    .resetn(resetn),
    .start(start_evt),
    .chan_mask(cfg_sel_r),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .adc_start_r(adc_start),
    .adc_chan_r(adc_chan),
    .busy_r(seq_busy),
    .res_valid_r(seq_res_valid),
    .res_chan_r(seq_res_chan),
    .res_data_r(seq_res_data)
  );

  // outputs straight from flops
  assign lnk_req_busy = pend_r;
  assign lnk_rd_ready = rd_ready_r;
  assign lnk_rd_byte = rd_byte_r;
  assign bus_glitch_filter_enable = cfg_flt_r;
  assign viol_status = viol_status_r;
  assign status_pin_out = pin_out_r;
  assign status_pin_oe = pin_oe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // clear write without new violation
  sequence s_clear_only;
    clr_all && !res_over;
  endsequence
  a_clear_flag: assert property (s_clear_only |=>
    !viol_flag_r && viol_status_r == 8'h00)
    else $error("clear write left violation state");
  a_clear_readback: assert property (clr_all |=> cfg_en_r && !cfg_ba_r)
    else $error("clear readback not enable one select zero");
  a_over_sets: assert property (res_over |=>
    viol_flag_r ##1 (viol_flag_r || $past(clr_all)))
    else $error("violation flag not held");
  a_busy_pin: assert property (mode_busy |=>
    status_pin_out == ($past(cfg_pol_r) ? $past(seq_busy) : !$past(seq_busy)))
    else $error("busy pin wrong level");
  a_pin_oe_mode: assert property (##1 status_pin_oe == $past(mode_busy || mode_alert))
    else $error("pin enable does not follow role");
  a_tag_capture: assert property (seq_res_valid |=> res_tag_r == $past(seq_res_chan))
    else $error("channel tag not captured");
  a_ten_bit_low: assert property (TEN_BIT |-> res_data_r[1:0] == 2'b00)
    else $error("ten-bit low bits not zero");
  a_filter_follow: assert property (wr_cfg |=>
    bus_glitch_filter_enable == $past(req_data_r[`ACR_CFG_FLT]))
    else $error("filter bit not written");
  // a result above its limit marks the upper bit of its channel
  a_status_sets: assert property (res_over |=> viol_status_r[$past(over_bit)])
    else $error("violation status bit not set");
  // alert role shows the flag at the chosen level
  a_alert_pin: assert property (mode_alert |=>
    status_pin_out == ($past(cfg_pol_r) ? $past(viol_flag_r) : !$past(viol_flag_r)))
    else $error("alert pin wrong level");
  // twelve-bit build stores the data word untouched
  a_result_data: assert property (seq_res_valid && !TEN_BIT |=>
    res_data_r == $past(seq_res_data))
    else $error("result data not stored");
  // select bits follow the written word
  a_sel_write: assert property (wr_cfg |=>
    cfg_sel_r == $past(req_data_r[`ACR_CFG_SEL_HI:`ACR_CFG_SEL_LO]))
    else $error("channel select not written");
  // the flag stays until a clear write
  a_flag_sticky: assert property (viol_flag_r && !clr_all |=> viol_flag_r)
    else $error("violation flag dropped without clear");
  // polarity bit follows the written word
  a_pol_write: assert property (wr_cfg |=>
    cfg_pol_r == $past(req_data_r[`ACR_CFG_POL]))
    else $error("polarity bit not written");
  a_link_high_first: assert property (@(posedge link_clk) disable iff (!lnk_rst_n)
    $rose(rd_ready_r) |-> rd_byte_r == ans_word_r[15:8] && !byte_lo_r)
    else $error("result byte order wrong");
  // first acknowledge turns the offer over to the low byte
  a_link_low_second: assert property (@(posedge link_clk) disable iff (!lnk_rst_n)
    rd_ready_r && lnk_byte_ack && !byte_lo_r |=> rd_byte_r == ans_word_r[7:0] && byte_lo_r)
    else $error("low result byte not offered");
endmodule

// *** logic/acr_seq.sv ***
// channel sequencer: walks the selected channels lowest first
// assumes the converter answers each start with one done pulse
`timescale 1ns/100ps
module acr_seq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] chan_mask,
  input wire logic adc_done,
  input wire acr_pkg::acr_data_t adc_data,
  output logic adc_start_r,
  output logic [2:0] adc_chan_r,
  output logic busy_r,
  output logic res_valid_r,
  output logic [2:0] res_chan_r,
  output acr_pkg::acr_data_t res_data_r
);
  import acr_pkg::*;

  // lowest set bit at or above from; bit 3 of the answer flags found
  function automatic logic [3:0] next_chan(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (m[i] && (4'(i) >= from))
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  acr_seq_state_t state_r;
  // mask latched at start so a mid-sequence write cannot skip channels
  logic [7:0] mask_r;
  // first channel of a fresh sequence
  wire logic [3:0] first_w = next_chan(chan_mask, 4'h0);
  // channel after the one just converted
  wire logic [3:0] after_w = next_chan(mask_r, {1'b0, adc_chan_r} + 4'h1);

  // sequence control
  always_ff @(posedge clk)
  begin
    adc_start_r <= 1'b0;
    res_valid_r <= 1'b0;
    if (!resetn)
    begin
      state_r <= ACR_SEQ_IDLE;
      mask_r <= 8'h00;
      adc_chan_r <= 3'h0;
      busy_r <= 1'b0;
      res_chan_r <= 3'h0;
      res_data_r <= 12'h000;
    end
    else
    begin
      case (state_r)
        // empty mask ignores the start
        ACR_SEQ_IDLE:
        begin
          if (start && first_w[3])
          begin
            mask_r <= chan_mask;
            adc_chan_r <= first_w[2:0];
            adc_start_r <= 1'b1;
            busy_r <= 1'b1;
            state_r <= ACR_SEQ_CONV;
          end
        end
        // wait for each result, then move up
        ACR_SEQ_CONV:
        begin
          if (adc_done)
          begin
            res_valid_r <= 1'b1;
            res_chan_r <= adc_chan_r;
            res_data_r <= adc_data;
            if (after_w[3])
            begin
              adc_chan_r <= after_w[2:0];
              adc_start_r <= 1'b1;
            end
            else
            begin
              busy_r <= 1'b0;
              state_r <= ACR_SEQ_IDLE;
            end
          end
        end
        default:
          state_r <= ACR_SEQ_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // a start with a mask launches on its lowest channel
  sequence s_launch;
    start && state_r == ACR_SEQ_IDLE && first_w[3];
  endsequence
  a_seq_lowest_first: assert property (s_launch |=>
    adc_start_r && adc_chan_r == $past(first_w[2:0]))
    else $error("sequence did not start at lowest channel");
  // never a channel that is not selected
  a_seq_chan_sel: assert property (adc_start_r |-> mask_r[adc_chan_r])
    else $error("converted channel not selected");
  // busy covers every launch
  a_seq_busy_cover: assert property (adc_start_r |-> busy_r)
    else $error("launch outside busy");
endmodule

// *** logic/acr_sync.sv ***
// two-flop synchroniser for levels and toggles
// assumes the input is stable for at least two destination edges
`timescale 1ns/100ps
module acr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // first stage, read only by the second
  logic [WIDTH-1:0] meta_r;

  // plain two-stage chain, no reset so it settles from the input
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule
